/* File: verilog/sep_port.sv */
// Serial command port of a 512-byte nonvolatile memory
module sep_port #(
  parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
  // System
  input wire logic CLK,
  input wire logic RST,
  // Serial link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE_N
);

  //----------------------------------------------------------------------------
  // Checks and declarations
  //----------------------------------------------------------------------------
  if (PROG_CYCLES < 1 || PROG_CYCLES >= 2 ** sep_pkg::CNT_W) begin : g_bad_cycles
    $error("PROG_CYCLES out of range");
  end

  localparam logic [sep_pkg::CNT_W-1:0] LAST_CNT = sep_pkg::CNT_W'(PROG_CYCLES - 1);

  logic [sep_pkg::DATA_W-1:0] mem [0:(2 ** sep_pkg::ADDR_W)-1];

  // Link side
  sep_pkg::sep_link_t state;
  sep_pkg::sep_link_t cur_state;
  sep_pkg::sep_link_t next_state;
  logic cs_set;
  logic cs_high_seen;
  logic frame_live;
  logic first;
  logic active;
  logic cur_act;
  logic [2:0] bit_idx;
  logic [2:0] cur_idx;
  logic byte_end;
  logic [6:0] shift;
  logic [7:0] rx_byte;
  logic is_read;
  logic addr_hi;
  logic [sep_pkg::ADDR_W-1:0] rd_addr;
  logic [7:0] tx;
  logic [3:0] req;
  logic [7:0] sr_data;
  logic [7:0] wbuf [0:sep_pkg::PAGE_BYTES-1];
  logic [sep_pkg::PAGE_BYTES-1:0] wmask;
  logic [sep_pkg::PAGE_W-1:0] wptr;
  logic [sep_pkg::ADDR_W-1:0] waddr;
  logic [sep_pkg::STAT_W-1:0] st_meta;
  logic [sep_pkg::STAT_W-1:0] st_s;
  logic [7:0] status_byte;

  // System side
  sep_pkg::sep_prog_t pstate;
  logic [sep_pkg::CNT_W-1:0] prog_cnt;
  logic cs_m;
  logic cs_s;
  logic cs_d;
  logic cs_e;
  logic cs_rise;
  logic wp_m;
  logic wp_s;
  logic wp_low_seen;
  logic [3:0] req_m;
  logic [3:0] req_s;
  logic latch_flag;
  logic [1:0] bp;
  logic busy;
  logic commit_arr;
  logic write_go;
  logic finish;

  //----------------------------------------------------------------------------
  // Decode helpers
  //----------------------------------------------------------------------------
  function automatic logic arr_op(input logic [7:0] op, input logic [2:0] low);
    arr_op = (op[7:4] == sep_pkg::OP_ARR_TOP) && (op[2:0] == low);
  endfunction

  function automatic logic is_protected(input logic [8:0] a, input logic [1:0] sel);
    unique case (sel)
      sep_pkg::PROT_NONE: is_protected = 1'b0;
      sep_pkg::PROT_QUARTER: is_protected = (a >= sep_pkg::QUARTER_BASE);
      sep_pkg::PROT_HALF: is_protected = (a >= sep_pkg::HALF_BASE);
      default: is_protected = 1'b1;
    endcase
  endfunction

  //----------------------------------------------------------------------------
  // Frame tracking on the serial clock
  //----------------------------------------------------------------------------
  assign cs_set = CS_N & ~RST;

  // Armed once select has been high since reset
  always_ff @(posedge SCK or posedge RST or posedge cs_set) begin
    if (RST) begin
      cs_high_seen <= 1'b0; // [R4]
    end else if (cs_set) begin
      cs_high_seen <= 1'b1; // [R4]
    end else begin
      cs_high_seen <= cs_high_seen;
    end
  end

  // Cleared by deselect, set by first unpaused edge
  always_ff @(posedge SCK or posedge RST or posedge CS_N) begin
    if (RST || CS_N) begin
      frame_live <= 1'b0;
    end else if (HOLD_N) begin
      frame_live <= 1'b1; // [R11]
    end
  end

  assign first = ~frame_live;
  assign cur_state = first ? sep_pkg::LK_OP : state;
  assign cur_idx = first ? 3'h0 : bit_idx;
  assign cur_act = first ? cs_high_seen : active;
  assign byte_end = (cur_idx == 3'h7);
  assign rx_byte = {shift, SI}; // [R9]
  assign status_byte = st_s[sep_pkg::ST_BUSY_BIT] ? sep_pkg::STATUS_WHILE_BUSY // [R17]
                     : {4'h0, st_s[3:1], 1'b0}; // [R15] [R18]

  always_comb begin
    next_state = cur_state;
    if (!cur_act) begin
      next_state = sep_pkg::LK_IGNORE;
    end else if (byte_end) begin
      unique case (cur_state)
        sep_pkg::LK_OP: begin
          if (rx_byte == sep_pkg::OP_STAT_RD) begin
            next_state = sep_pkg::LK_STAT; // [R14]
          end else if (rx_byte == sep_pkg::OP_STAT_WR) begin
            next_state = sep_pkg::LK_SDATA;
          end else if (arr_op(rx_byte, sep_pkg::OP_ARR_RD)) begin
            next_state = sep_pkg::LK_ADDR; // [R20]
          end else if (arr_op(rx_byte, sep_pkg::OP_ARR_WR)) begin
            next_state = sep_pkg::LK_ADDR; // [R21]
          end else begin
            next_state = sep_pkg::LK_IGNORE; // [R27]
          end
        end
        sep_pkg::LK_ADDR: begin
          next_state = is_read ? sep_pkg::LK_RDATA : sep_pkg::LK_WDATA;
        end
        sep_pkg::LK_RDATA, sep_pkg::LK_WDATA, sep_pkg::LK_SDATA,
        sep_pkg::LK_STAT, sep_pkg::LK_IGNORE: begin
          next_state = cur_state;
        end
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Input shifting, all but the st_meta/st_s status sync frozen while paused
  //----------------------------------------------------------------------------
  always_ff @(posedge SCK or posedge RST) begin
    if (RST) begin
      state <= sep_pkg::LK_IGNORE;
      bit_idx <= 3'h0;
      shift <= 7'h00;
      active <= 1'b0;
    end else if (HOLD_N) begin // [R8]
      state <= next_state;
      bit_idx <= cur_idx + 3'h1;
      shift <= rx_byte[6:0]; // [R1]
      active <= cur_act;
    end
  end

  // Opcode fields kept for the address phase
  always_ff @(posedge SCK or posedge RST) begin
    if (RST) begin
      is_read <= 1'b0;
      addr_hi <= 1'b0;
    end else if (HOLD_N && byte_end && cur_state == sep_pkg::LK_OP) begin
      is_read <= arr_op(rx_byte, sep_pkg::OP_ARR_RD);
      addr_hi <= rx_byte[sep_pkg::OP_ADDR_BIT]; // [R20] [R21]
    end
  end

  // Output byte and streaming read address
  always_ff @(posedge SCK or posedge RST) begin
    if (RST) begin
      tx <= 8'h00;
      rd_addr <= 9'h000;
    end else if (HOLD_N && byte_end && cur_act) begin
      if ((cur_state == sep_pkg::LK_OP && rx_byte == sep_pkg::OP_STAT_RD)
          || cur_state == sep_pkg::LK_STAT) begin
        tx <= status_byte; // [R14]
      end else if (cur_state == sep_pkg::LK_ADDR && is_read) begin
        tx <= mem[{addr_hi, rx_byte}];
        rd_addr <= {addr_hi, rx_byte} + 9'h001;
      end else if (cur_state == sep_pkg::LK_RDATA) begin
        tx <= mem[rd_addr];
        rd_addr <= rd_addr + 9'h001; // [R23]
      end
    end
  end

  // Requests for the system side, cleared at each frame start
  always_ff @(posedge SCK or posedge RST) begin
    if (RST) begin
      req <= 4'h0;
    end else if (HOLD_N) begin
      if (first) begin
        req <= 4'h0;
      end
      if (cur_act && byte_end && cur_state == sep_pkg::LK_OP) begin
        req[sep_pkg::RQ_SET] <= (rx_byte == sep_pkg::OP_LATCH_SET); // [R12]
        req[sep_pkg::RQ_CLR] <= (rx_byte == sep_pkg::OP_LATCH_CLR); // [R12]
      end
      // Valid only right after the last bit of a data byte
      req[sep_pkg::RQ_ARR] <= cur_act && byte_end && cur_state == sep_pkg::LK_WDATA // [R25]
                              && !st_s[sep_pkg::ST_BUSY_BIT];
      req[sep_pkg::RQ_SR] <= cur_act && byte_end && cur_state == sep_pkg::LK_SDATA // [R25]
                             && !st_s[sep_pkg::ST_BUSY_BIT];
    end
  end

  // Page buffer, frozen while programming
  always_ff @(posedge SCK or posedge RST) begin
    if (RST) begin
      wmask <= '0;
      wptr <= '0;
      waddr <= '0;
      sr_data <= 8'h00;
    end else if (HOLD_N && byte_end && cur_act && !st_s[sep_pkg::ST_BUSY_BIT]) begin
      if (cur_state == sep_pkg::LK_ADDR && !is_read) begin
        waddr <= {addr_hi, rx_byte};
        wptr <= rx_byte[sep_pkg::PAGE_W-1:0];
        wmask <= '0;
      end else if (cur_state == sep_pkg::LK_WDATA) begin
        wmask[wptr] <= 1'b1;
        wptr <= wptr + 2'h1; // [R24]
      end else if (cur_state == sep_pkg::LK_SDATA) begin
        sr_data <= rx_byte;
      end
    end
  end

  always_ff @(posedge SCK) begin
    if (HOLD_N && byte_end && cur_act && cur_state == sep_pkg::LK_WDATA
        && !st_s[sep_pkg::ST_BUSY_BIT]) begin
      wbuf[wptr] <= rx_byte; // [R24]
    end
  end

  // Status bits brought onto the serial clock
  always_ff @(posedge SCK or posedge RST) begin
    if (RST) begin
      st_meta <= '0;
      st_s <= '0;
    end else begin
      st_meta <= {bp, latch_flag, busy};
      st_s <= st_meta;
    end
  end

  //----------------------------------------------------------------------------
  // Serial output on the falling edge
  //----------------------------------------------------------------------------
  always_ff @(negedge SCK or posedge RST or posedge CS_N) begin
    if (RST || CS_N) begin
      SO <= 1'b0;
      SO_OE_N <= 1'b1; // [R3]
    end else if (HOLD_N) begin // [R8]
      SO <= tx[~bit_idx]; // [R2] [R9]
      SO_OE_N <= !(frame_live && active
                   && (state == sep_pkg::LK_RDATA || state == sep_pkg::LK_STAT));
    end
  end

  //----------------------------------------------------------------------------
  // Crossings into the system clock
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      cs_e <= 1'b1;
      wp_m <= 1'b0;
      wp_s <= 1'b0;
      req_m <= 4'h0;
      req_s <= 4'h0;
    end else begin
      cs_m <= CS_N;
      cs_s <= cs_m;
      cs_d <= cs_s;
      cs_e <= cs_d;
      wp_m <= WP_N;
      wp_s <= wp_m;
      req_m <= req;
      req_s <= req_m;
    end
  end

  // Extra stage lets the request levels settle before use
  assign cs_rise = cs_d & ~cs_e;

  // Guard seen low anywhere inside the frame
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wp_low_seen <= 1'b0;
    end else if (!cs_s && !wp_s) begin
      wp_low_seen <= 1'b1; // [R6]
    end else if (cs_e) begin
      wp_low_seen <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // Programming sequencer
  //----------------------------------------------------------------------------
  assign busy = (pstate == sep_pkg::PG_BUSY);
  assign finish = busy && prog_cnt == LAST_CNT;
  assign write_go = cs_rise && !busy && latch_flag && wp_s && !wp_low_seen // [R5] [R6] [R12]
                    && (req_s[sep_pkg::RQ_SR] // [R16]
                        || (req_s[sep_pkg::RQ_ARR] && !is_protected(waddr, bp))); // [R19]

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pstate <= sep_pkg::PG_IDLE;
      prog_cnt <= '0;
      commit_arr <= 1'b0;
    end else begin
      unique case (pstate)
        sep_pkg::PG_IDLE: begin
          if (write_go) begin
            pstate <= sep_pkg::PG_BUSY; // [R22]
            prog_cnt <= '0;
            commit_arr <= req_s[sep_pkg::RQ_ARR];
          end
        end
        sep_pkg::PG_BUSY: begin
          if (finish) begin
            pstate <= sep_pkg::PG_IDLE;
          end else begin
            prog_cnt <= prog_cnt + 1'b1; // [R22]
          end
        end
      endcase
    end
  end

  // Write-enable latch
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      latch_flag <= 1'b0; // [R13]
    end else if (finish) begin
      latch_flag <= 1'b0; // [R13]
    end else if (cs_rise && !busy && req_s[sep_pkg::RQ_SET]) begin
      latch_flag <= 1'b1; // [R12] [R26]
    end else if (cs_rise && !busy && req_s[sep_pkg::RQ_CLR]) begin
      latch_flag <= 1'b0; // [R12]
    end
  end

  // Protect field, changed only by a finished status write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bp <= sep_pkg::PROT_RESET;
    end else if (finish && !commit_arr) begin
      bp <= sr_data[sep_pkg::ST_PROT_HI_BIT:sep_pkg::ST_PROT_LO_BIT]; // [R16]
    end
  end

  // Array cells take the page at the end of programming
  always_ff @(posedge CLK) begin
    if (finish && commit_arr) begin
      for (int i = 0; i < sep_pkg::PAGE_BYTES; i++) begin
        if (wmask[i]) begin
          mem[{waddr[8:2], 2'(i)}] <= wbuf[i]; // [R24]
        end
      end
    end
  end

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  property p_latch_set;
    @(posedge CLK) disable iff (RST)
    cs_rise && !busy && req_s[sep_pkg::RQ_SET] |=> latch_flag;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set"); // [R12]

  property p_no_latch_no_write;
    @(posedge CLK) disable iff (RST)
    cs_rise && !busy && !latch_flag |=> !busy;
  endproperty
  a_no_latch_no_write: assert property (p_no_latch_no_write) // [R12]
    else $error("programming without latch");

  property p_end_clears;
    @(posedge CLK) disable iff (RST)
    finish |=> !latch_flag && !busy;
  endproperty
  a_end_clears: assert property (p_end_clears) else $error("latch kept after programming"); // [R13]

  property p_busy_holds;
    @(posedge CLK) disable iff (RST)
    busy && prog_cnt < LAST_CNT |=> busy && prog_cnt == $past(prog_cnt) + 1'b1;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("programming cut short"); // [R22]

  property p_guard_blocks;
    @(posedge CLK) disable iff (RST)
    cs_rise && !busy && (!wp_s || wp_low_seen) |=> !busy;
  endproperty
  a_guard_blocks: assert property (p_guard_blocks) else $error("write with guard low"); // [R5]

  property p_protect_blocks;
    @(posedge CLK) disable iff (RST)
    cs_rise && !busy && !req_s[sep_pkg::RQ_SR] && is_protected(waddr, bp) |=> !busy;
  endproperty
  a_protect_blocks: assert property (p_protect_blocks) // [R19]
    else $error("write into protected range");

  property p_deselect_release;
    @(posedge CLK) disable iff (RST)
    cs_s |-> SO_OE_N;
  endproperty
  a_deselect_release: assert property (p_deselect_release) // [R3]
    else $error("output driven while deselected");

  property p_status_cmd;
    @(posedge SCK) disable iff (RST || CS_N)
    HOLD_N && cur_act && byte_end && cur_state == sep_pkg::LK_OP
      && rx_byte == sep_pkg::OP_STAT_RD |=> state == sep_pkg::LK_STAT && tx == $past(status_byte);
  endproperty
  a_status_cmd: assert property (p_status_cmd) else $error("status read not taken"); // [R14]

  property p_pause_freeze;
    @(posedge SCK) disable iff (RST || CS_N)
    !HOLD_N && frame_live |=> $stable(bit_idx) && $stable(state) && $stable(shift);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) else $error("sequence moved in pause"); // [R8]

  property p_busy_status;
    @(posedge SCK) disable iff (RST)
    st_s[sep_pkg::ST_BUSY_BIT] |-> status_byte == sep_pkg::STATUS_WHILE_BUSY;
  endproperty
  a_busy_status: assert property (p_busy_status) else $error("busy status not all ones"); // [R17]

endmodule

/* File: verilog/sep_pkg.sv */
// Constants and types of the serial memory command port
//------------------------------------------------------------------------------
// Function
// [R1] Input bits sampled on rising serial clock
// [R2] Output bits change after falling serial clock
// [R3] Deselected: output released, programming continues
// [R4] First falling select after power-up needed
// [R5] Guard low refuses all nonvolatile writes
// [R6] Guard fall in frame aborts; programming continues
// [R7] Host moves pause only while clock low
// [R8] Pause freezes sequence; resume from same bit
// [R9] Eight-bit instructions; everything most significant first
// [R10] Host keeps select low, pause/guard high
// [R11] First bit on first rise; clock static
// [R12] Opcodes set/clear latch; writes need latch
// [R13] Latch cleared at power-up and programming end
// [R14] Status read accepted at any time
// [R15] Status: busy 0, latch 1, protect 3:2
// [R16] Only status write alters protect bits
// [R17] Busy one while programming; others then one
// [R18] Latch flag mirrors write-enable latch
// [R19] Protect field selects quarter, half or all
// [R20] Array read opcode carries ninth address bit
// [R21] Array write opcode carries ninth address bit
// [R22] Self-timed programming about 5ms, busy set
// [R23] Read address increments, wraps to zero
// [R24] At most 4 bytes, wrapping in page
// [R25] Write starts only if select rises on byte end
// [R26] Write in latch-set frame is ignored
// [R27] Unknown opcode is no operation until deselect
//------------------------------------------------------------------------------
package sep_pkg;
  // Geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 4;
  localparam int PAGE_W = 2;
  localparam int STAT_W = 4;
  // Opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [3:0] OP_ARR_TOP = 4'h0;
  localparam int OP_ADDR_BIT = 3;
  localparam logic [2:0] OP_ARR_RD = 3'h3;
  localparam logic [2:0] OP_ARR_WR = 3'h2;
  // Status byte fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_PROT_LO_BIT = 2;
  localparam int ST_PROT_HI_BIT = 3;
  localparam logic [7:0] STATUS_WHILE_BUSY = 8'hff;
  // Protect selections
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_QUARTER = 2'h1;
  localparam logic [1:0] PROT_HALF = 2'h2;
  localparam logic [1:0] PROT_ALL = 2'h3;
  localparam logic [8:0] QUARTER_BASE = 9'h180;
  localparam logic [8:0] HALF_BASE = 9'h100;
  localparam logic [1:0] PROT_RESET = 2'h0;
  // Request bits handed from the link side
  localparam int RQ_SET = 0;
  localparam int RQ_CLR = 1;
  localparam int RQ_ARR = 2;
  localparam int RQ_SR = 3;
  // Programming time
  localparam int PROG_TIME_NS = 5000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  // States
  typedef enum logic [2:0] {
    LK_OP, LK_ADDR, LK_RDATA, LK_WDATA, LK_SDATA, LK_STAT, LK_IGNORE
  } sep_link_t;
  typedef enum logic {PG_IDLE, PG_BUSY} sep_prog_t;
endpackage

/* File: dv/sep_host.sv */
// Host controller model driving the serial link
module sep_host (
  // Link outputs
  output logic SCK,
  output logic CS_N,
  output logic SI,
  output logic HOLD_N,
  // Link inputs
  input wire logic SO,
  input wire logic SO_OE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 6ns;

  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
    HOLD_N = 1'b1;
  end

  // Open a frame with a falling select
  task automatic sel();
    #HALF;
    CS_N = 1'b0;
    #HALF;
  endtask

  // Close a frame; clock stands low, data line scrambled
  task automatic desel();
    CS_N = 1'b1;
    SI = ~SI;
    #400ns;
  endtask

  // Shift bits out and capture the answer on each rise
  task automatic bits(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      SI = tx[i];
      #HALF;
      SCK = 1'b1;
      rx = {rx[6:0], (SO_OE_N === 1'b0) ? SO : 1'bx};
      #HALF;
      SCK = 1'b0;
    end
  endtask

  // Pause with clock and data moving meanwhile
  task automatic pause();
    #HALF;
    HOLD_N = 1'b0;
    for (int i = 0; i < 3; i++) begin
      SI = ~SI;
      #HALF;
      SCK = 1'b1;
      #HALF;
      SCK = 1'b0;
    end
    #HALF;
    HOLD_N = 1'b1;
    #HALF;
  endtask
endmodule

/* File: dv/sep_port_test.sv */
// Self-checking bench of the serial memory command port
module sep_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK;
  logic RST;
  logic WP_N;
  logic SCK, CS_N, SI, HOLD_N, SO, SO_OE_N;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] r;

  sep_host HOST (.SCK(SCK), .CS_N(CS_N), .SI(SI), .HOLD_N(HOLD_N), .SO(SO), .SO_OE_N(SO_OE_N));
  sep_port #(.PROG_CYCLES(20)) DUT (.CLK(CLK), .RST(RST), .SCK(SCK), .CS_N(CS_N), .SI(SI),
    .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO), .SO_OE_N(SO_OE_N));

  initial begin
    CLK = 1'b0;
    forever #25ns CLK = ~CLK;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    HOST.sel();
    HOST.bits(8, op, r);
    HOST.desel();
  endtask

  task automatic stat(input logic [7:0] exp);
    HOST.sel();
    HOST.bits(8, sep_pkg::OP_STAT_RD, r);
    HOST.bits(8, 8'h00, r);
    HOST.desel();
    chk(r, exp);
  endtask

  task automatic wr(input logic [8:0] a, input logic [39:0] d, input int n, input int tail);
    HOST.sel();
    HOST.bits(8, {4'h0, a[8], sep_pkg::OP_ARR_WR}, r);
    HOST.bits(8, a[7:0], r);
    for (int i = 0; i < n; i++) HOST.bits(8, d[39-8*i -: 8], r);
    if (tail > 0) HOST.bits(tail, 8'hc3, r);
    HOST.desel();
  endtask

  task automatic rd(input logic [8:0] a, input logic [39:0] d, input int n);
    HOST.sel();
    HOST.bits(8, {4'h0, a[8], sep_pkg::OP_ARR_RD}, r);
    HOST.bits(8, a[7:0], r);
    for (int i = 0; i < n; i++) begin
      HOST.bits(8, 8'h00, r);
      chk(r, d[39-8*i -: 8]);
    end
    HOST.desel();
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      HOST.sel();
      HOST.bits(8, sep_pkg::OP_STAT_RD, r);
      HOST.bits(8, 8'h00, r);
      HOST.desel();
      k++;
    end while (r[0] !== 1'b0 && k < 30);
    if (k >= 30) begin
      miscompares++;
      $display("ERROR at %0t: programming never ended", $time);
    end
  endtask

  task automatic t_latch();
    stat(8'h00);
    cmd(sep_pkg::OP_LATCH_SET);
    stat(8'h02);
    cmd(sep_pkg::OP_LATCH_CLR);
    stat(8'h00);
    HOST.sel();
    HOST.bits(8, 8'hff, r);
    HOST.bits(8, sep_pkg::OP_LATCH_SET, r);
    HOST.desel();
    stat(8'h00);
    $display("latch test done");
  endtask

  task automatic t_page();
    cmd(sep_pkg::OP_LATCH_SET);
    wr(9'h1fd, 40'ha1a2a3a4a5, 5, 0);
    stat(8'hff);
    wait_idle();
    stat(8'h00);
    cmd(sep_pkg::OP_LATCH_SET);
    wr(9'h000, 40'h5a00000000, 1, 0);
    wait_idle();
    rd(9'h1fc, 40'ha4a5a2a35a, 5);
    $display("page test done");
  endtask

  task automatic t_refuse();
    wr(9'h000, 40'h1100000000, 1, 0);
    stat(8'h00);
    cmd(sep_pkg::OP_LATCH_SET);
    wr(9'h000, 40'h2200000000, 1, 4);
    stat(8'h02);
    HOST.sel();
    HOST.bits(8, sep_pkg::OP_LATCH_SET, r);
    HOST.bits(8, {4'h0, 1'b0, sep_pkg::OP_ARR_WR}, r);
    HOST.bits(8, 8'h00, r);
    HOST.bits(8, 8'h33, r);
    HOST.desel();
    stat(8'h02);
    @(negedge CLK) WP_N <= 1'b0;
    wr(9'h000, 40'h4400000000, 1, 0);
    stat(8'h02);
    rd(9'h000, 40'h5a00000000, 1);
    @(negedge CLK) WP_N <= 1'b1;
    HOST.sel();
    HOST.bits(8, {4'h0, 1'b0, sep_pkg::OP_ARR_WR}, r);
    HOST.bits(8, 8'h00, r);
    @(negedge CLK) WP_N <= 1'b0;
    repeat (4) @(negedge CLK);
    WP_N <= 1'b1;
    HOST.bits(8, 8'h55, r);
    HOST.desel();
    stat(8'h02);
    rd(9'h000, 40'h5a00000000, 1);
    $display("refusal test done");
  endtask

  task automatic t_hold();
    HOST.sel();
    HOST.bits(4, 8'h00, r);
    HOST.pause();
    HOST.bits(4, sep_pkg::OP_STAT_RD, r);
    HOST.pause();
    HOST.bits(8, 8'h00, r);
    HOST.desel();
    chk(r, 8'h02);
    cmd(sep_pkg::OP_LATCH_CLR);
    $display("pause test done");
  endtask

  task automatic t_protect();
    logic [8:0] base[4];
    base = '{9'h000, sep_pkg::QUARTER_BASE, sep_pkg::HALF_BASE, 9'h000};
    for (int m = 1; m < 4; m++) begin
      cmd(sep_pkg::OP_LATCH_SET);
      HOST.sel();
      HOST.bits(8, sep_pkg::OP_STAT_WR, r);
      HOST.bits(8, {4'h0, m[1:0], 2'h0}, r);
      HOST.desel();
      wait_idle();
      stat({4'h0, m[1:0], 2'h0});
      cmd(sep_pkg::OP_LATCH_SET);
      wr(base[m], 40'h7700000000, 1, 0);
      stat({4'h0, m[1:0], 2'h2});
    end
    rd(9'h000, 40'h5a00000000, 1);
    $display("protect test done");
  endtask

  task automatic t_power();
    HOST.sel();
    @(negedge CLK) RST <= 1'b1;
    repeat (2) @(negedge CLK);
    RST <= 1'b0;
    repeat (2) @(negedge CLK);
    HOST.bits(8, sep_pkg::OP_LATCH_SET, r);
    HOST.desel();
    stat(8'h00);
    $display("power-up test done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    RST = 1'b1;
    WP_N = 1'b1;
    repeat (8) @(negedge CLK);
    RST <= 1'b0;
    repeat (4) @(negedge CLK);
    t_latch();
    t_page();
    t_refuse();
    t_hold();
    t_protect();
    t_power();
    print_verdict();
  end

  initial begin
    #2ms;
    miscompares++;
    $display("ERROR at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
